// [common/subch_pkg.sv]
// Shared constants and types for the subchannel switching block
package subch_pkg;
    // Register byte offsets on the bus
    localparam logic [4:0] OFS_DATA = 5'h00;
    localparam logic [4:0] OFS_ADDR = 5'h04;
    localparam logic [4:0] OFS_CTRL = 5'h08;
    localparam logic [4:0] OFS_CSEL = 5'h0C;
    localparam logic [4:0] OFS_STAT = 5'h10;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_TS = 4'h0;
    localparam logic [7:0] IDLE_BYTE = 8'hFF;
    // Memory operation words written to the control register
    localparam logic [3:0] OP_CM_WRITE = 4'h7;
    localparam logic [7:0] OP_TS_WRITE = 8'h60;
    localparam logic [7:0] OP_PTR_WRITE = 8'h48;
    localparam logic [7:0] OP_PTR_READ = 8'hC8;
    localparam logic [7:0] OP_CODE_READ = 8'hF0;
    // Switching codes
    localparam logic [3:0] CODE_NONE = 4'h0;
    localparam logic [3:0] CODE_64K = 4'h1;
    localparam logic [3:0] CODE_32K_HI = 4'h3;
    localparam logic [3:0] CODE_16K_B0 = 4'h4;
    localparam logic [3:0] CODE_16K_B2 = 4'h6;
    localparam logic [3:0] CODE_16K_B6 = 4'h7;
    // Port subchannel select values
    localparam logic [1:0] SEL_LOW = 2'h3;
    localparam logic [1:0] SEL_MID = 2'h1;
    localparam logic [1:0] SEL_HIGH = 2'h2;
    // Field positions
    localparam int PTR_DIR_BIT = 7;
    localparam int CODE_MSB = 3;
    localparam int PORT_BITS = 2;
    // Bit masks of the subchannel widths
    localparam logic [7:0] MASK_8 = 8'hFF;
    localparam logic [7:0] MASK_4 = 8'h0F;
    localparam logic [7:0] MASK_2 = 8'h03;

    typedef struct packed {
        logic valid;
        logic [2:0] pcm_lsb;
        logic [2:0] cfi_lsb;
        logic [7:0] mask;
    } subch_t;
endpackage

// [rtl/subchan_map.sv]
// Decoder from switching code and port select to subchannel placement
`timescale 1ns/1ps
module subchan_map
    import subch_pkg::*;
(
    input wire logic [3:0] code,
    input wire logic [1:0] sel,
    output subch_t map
);
    always_comb begin
        map = '{valid: 1'b0, pcm_lsb: 3'h0, cfi_lsb: 3'h0, mask: MASK_8};
        if (code == CODE_64K) begin
            map.valid = 1'b1; // [RULE_05]
        end else if (code == CODE_16K_B0) begin
            map = '{valid: 1'b1, pcm_lsb: 3'h0, cfi_lsb: 3'h0, mask: MASK_2}; // [RULE_01]
        end else if (code == CODE_16K_B2) begin
            map = '{valid: 1'b1, pcm_lsb: 3'h2, cfi_lsb: 3'h0, mask: MASK_2}; // [RULE_02]
        end else if (code == CODE_32K_HI) begin
            map = '{valid: 1'b1, pcm_lsb: 3'h4, cfi_lsb: 3'h0, mask: MASK_4}; // [RULE_03]
        end else if (code == CODE_16K_B6) begin
            map = '{valid: 1'b1, pcm_lsb: 3'h6, cfi_lsb: 3'h0, mask: MASK_2}; // [RULE_04]
        end
        // Position inside the configurable-interface slot follows the port select
        if (map.mask == MASK_2) begin
            case (sel)
                SEL_LOW: map.cfi_lsb = 3'h0; // [RULE_09]
                SEL_MID: map.cfi_lsb = 3'h4; // [RULE_10]
                SEL_HIGH: map.cfi_lsb = 3'h2; // [RULE_11]
                default: map.cfi_lsb = 3'h6;
            endcase
        end else if (map.mask == MASK_4) begin
            case (sel)
                SEL_LOW: map.cfi_lsb = 3'h0; // [RULE_09]
                SEL_MID: map.cfi_lsb = 3'h0; // [RULE_10]
                SEL_HIGH: map.cfi_lsb = 3'h4; // [RULE_11]
                default: map.cfi_lsb = 3'h4;
            endcase
        end
    end
endmodule

// [rtl/subchannel_loop_switch_control.sv]
// Time slot switch with subchannel codes, tristate field and loops
//
// Our own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
// What this block does
// (RULE_01) Code 0100 switches PCM bits 1..0
// (RULE_02) Code 0110 switches PCM bits 3..2
// (RULE_03) Code 0011 switches PCM bits 7..4
// (RULE_04) Code 0111 switches PCM bits 7..6
// (RULE_05) Code 0001 switches the full byte
// (RULE_06) Operation 0110 0000 writes tristate field
// (RULE_07) All-zero tristate field releases the whole slot
// (RULE_08) Tristate bit k drives bits 2k+1, 2k
// (RULE_09) Select 11: 16k at 1..0, 32k at 3..0
// (RULE_10) Select 01: 16k at 5..4, 32k at 3..0
// (RULE_11) Select 10: 16k at 3..2, 32k at 7..4
// (RULE_12) Same-interface loops route over the opposite interface
// (RULE_13) PCM loop uses spare downstream and upstream slots
// (RULE_14) Software may release the loop's opposite slot
// (RULE_15) Software points source upstream entry to spare slot
// (RULE_16) Spare slot drive follows its tristate field
// (RULE_17) Same pointer downstream reads the upstream memory
// (RULE_18) One subchannel per interface slot, many per PCM
// (RULE_19) Leading-zero code marks a switched channel
module subchannel_loop_switch_control
    import subch_pkg::*;
#(
    parameter int NSLOT = 32,
    parameter int SW = 5
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [4:0] ADR_I,
    input wire logic [31:0] DAT_I,
    input wire logic [3:0] SEL_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    input wire logic [7:0] PCM_RX_DATA,
    input wire logic [7:0] CFI_RX_DATA,
    output logic [7:0] PCM_TX_DATA,
    output logic [7:0] PCM_TX_OE,
    output logic [7:0] CFI_TX_DATA,
    output logic [SW-1:0] TX_SLOT
);
    // Control memory entry: code in the upper nibble, pointer in the low byte
    typedef struct packed {
        logic [3:0] code;
        logic [7:0] ptr;
    } cm_entry_t;

    typedef struct packed {
        cm_entry_t [NSLOT-1:0] cm_dn;
        cm_entry_t [NSLOT-1:0] cm_up;
        logic [NSLOT-1:0][7:0] dm_dn;
        logic [NSLOT-1:0][7:0] dm_up;
        logic [NSLOT-1:0][3:0] ts;
        logic [7:0] mem_access_data_reg;
        logic [7:0] mem_access_addr_reg;
        logic [7:0] mem_access_ctrl_reg;
        logic [7:0] cfi_subchannel_select_reg;
        logic pend;
        logic [SW-1:0] slot;
        logic [SW-1:0] tx_slot;
        logic [7:0] pcm_tx;
        logic [7:0] pcm_oe;
        logic [7:0] cfi_tx;
        logic ack;
        logic [31:0] dat;
    } state_t;

    state_t s_reg;
    state_t s_next;

    cm_entry_t dn_entry;
    cm_entry_t up_entry;
    logic [1:0] port_sel;
    subch_t dn_map;
    subch_t up_map;

    logic [SW-1:0] cur;
    logic [SW-1:0] dn_idx;
    logic [SW-1:0] up_idx;
    logic [SW-1:0] acc_idx;
    logic [7:0] dn_src;
    logic [7:0] dn_bits;
    logic [7:0] cfi_out;
    logic [7:0] up_src;
    logic [7:0] up_bits;
    logic [7:0] up_keep;
    logic bus_req;

    // Expand a tristate field to one enable per slot bit
    function automatic logic [7:0] expand_ts(input logic [3:0] f);
        logic [7:0] oe;
        oe = 8'h00;
        for (int k = 0; k < 4; k++) begin
            oe[2*k] = f[k];
            oe[2*k+1] = f[k];
        end
        return oe;
    endfunction

    // Leading-zero, non-zero code means the slot is switched
    function automatic logic is_switched(input logic [3:0] c);
        return (c[CODE_MSB] == 1'b0) && (c != CODE_NONE);
    endfunction

    assign cur = s_reg.slot;
    assign dn_entry = s_reg.cm_dn[cur];
    assign up_entry = s_reg.cm_up[cur];
    assign port_sel = s_reg.cfi_subchannel_select_reg[2*cur[PORT_BITS-1:0] +: 2];
    assign dn_idx = dn_entry.ptr[SW-1:0];
    assign up_idx = up_entry.ptr[SW-1:0];
    assign acc_idx = s_reg.mem_access_addr_reg[SW-1:0];
    assign bus_req = CYC_I && STB_I && !s_reg.ack;

    subchan_map u_dn_map (
        .code(dn_entry.code),
        .sel(port_sel),
        .map(dn_map)
    );

    subchan_map u_up_map (
        .code(up_entry.code),
        .sel(port_sel),
        .map(up_map)
    );

    // Downstream path: pick the data memory the pointer names
    always_comb begin
        if (dn_entry.ptr[PTR_DIR_BIT]) begin
            dn_src = s_reg.dm_up[dn_idx]; // [RULE_17] [RULE_12]
        end else begin
            dn_src = s_reg.dm_dn[dn_idx];
        end
        dn_bits = (dn_src >> dn_map.pcm_lsb) & dn_map.mask;
        cfi_out = IDLE_BYTE;
        if (is_switched(dn_entry.code) && dn_map.valid) begin // [RULE_19]
            // Only one subchannel lands in the slot; the rest stays idle
            cfi_out = (IDLE_BYTE & ~(dn_map.mask << dn_map.cfi_lsb))
                | (dn_bits << dn_map.cfi_lsb); // [RULE_18]
        end
    end

    // Upstream path: merge the subchannel into the addressed PCM byte
    always_comb begin
        if (up_entry.ptr[PTR_DIR_BIT]) begin
            up_src = CFI_RX_DATA;
        end else begin
            // Pointer with cleared direction bit takes the internal downstream output
            up_src = cfi_out; // [RULE_13]
        end
        up_bits = (up_src >> up_map.cfi_lsb) & up_map.mask;
        up_keep = s_reg.dm_up[up_idx] & ~(up_map.mask << up_map.pcm_lsb); // [RULE_18]
    end

    always_comb begin
        s_next = s_reg;
        s_next.slot = SW'(s_reg.slot + 1'b1);
        s_next.tx_slot = cur;

        // Receive side fills the data memories
        s_next.dm_dn[cur] = PCM_RX_DATA;
        if (is_switched(up_entry.code) && up_map.valid) begin // [RULE_19]
            s_next.dm_up[up_idx] = up_keep | (up_bits << up_map.pcm_lsb); // [RULE_12]
        end

        // Transmit side; a released bit pair is not driven
        s_next.cfi_tx = cfi_out;
        s_next.pcm_tx = s_reg.dm_up[cur];
        s_next.pcm_oe = expand_ts(s_reg.ts[cur]); // [RULE_07] [RULE_08] [RULE_16]

        // Memory operation runs one cycle after the control write
        if (s_reg.pend) begin
            s_next.pend = 1'b0;
            if (s_reg.mem_access_ctrl_reg == OP_TS_WRITE) begin
                s_next.ts[acc_idx] = s_reg.mem_access_data_reg[3:0]; // [RULE_06]
            end else if (s_reg.mem_access_ctrl_reg == OP_PTR_WRITE) begin
                if (s_reg.mem_access_addr_reg[PTR_DIR_BIT]) begin
                    s_next.cm_up[acc_idx].ptr = s_reg.mem_access_data_reg;
                end else begin
                    s_next.cm_dn[acc_idx].ptr = s_reg.mem_access_data_reg;
                end
            end else if (s_reg.mem_access_ctrl_reg[7:4] == OP_CM_WRITE) begin
                // Pointer and code are stored together, as for loops
                if (s_reg.mem_access_addr_reg[PTR_DIR_BIT]) begin
                    s_next.cm_up[acc_idx] = '{code: s_reg.mem_access_ctrl_reg[3:0], ptr: s_reg.mem_access_data_reg};
                end else begin
                    s_next.cm_dn[acc_idx] = '{code: s_reg.mem_access_ctrl_reg[3:0], ptr: s_reg.mem_access_data_reg};
                end
            end else if (s_reg.mem_access_ctrl_reg == OP_PTR_READ) begin
                if (s_reg.mem_access_addr_reg[PTR_DIR_BIT]) begin
                    s_next.mem_access_data_reg = s_reg.cm_up[acc_idx].ptr;
                end else begin
                    s_next.mem_access_data_reg = s_reg.cm_dn[acc_idx].ptr;
                end
            end else if (s_reg.mem_access_ctrl_reg == OP_CODE_READ) begin
                if (s_reg.mem_access_addr_reg[PTR_DIR_BIT]) begin
                    s_next.mem_access_data_reg = {4'h0, s_reg.cm_up[acc_idx].code};
                end else begin
                    s_next.mem_access_data_reg = {4'h0, s_reg.cm_dn[acc_idx].code};
                end
            end
        end

        // Bus slave: answer one cycle after the request, drop ack the next
        s_next.ack = bus_req;
        s_next.dat = 32'h0000_0000;
        if (bus_req && WE_I && SEL_I[0]) begin
            if (ADR_I == OFS_DATA) begin
                s_next.mem_access_data_reg = DAT_I[7:0];
            end else if (ADR_I == OFS_ADDR) begin
                s_next.mem_access_addr_reg = DAT_I[7:0];
            end else if (ADR_I == OFS_CTRL) begin
                s_next.mem_access_ctrl_reg = DAT_I[7:0];
                s_next.pend = 1'b1;
            end else if (ADR_I == OFS_CSEL) begin
                s_next.cfi_subchannel_select_reg = DAT_I[7:0];
            end
        end else if (bus_req && !WE_I) begin
            if (ADR_I == OFS_DATA) begin
                s_next.dat = {24'h00_0000, s_reg.mem_access_data_reg};
            end else if (ADR_I == OFS_ADDR) begin
                s_next.dat = {24'h00_0000, s_reg.mem_access_addr_reg};
            end else if (ADR_I == OFS_CTRL) begin
                s_next.dat = {24'h00_0000, s_reg.mem_access_ctrl_reg};
            end else if (ADR_I == OFS_CSEL) begin
                s_next.dat = {24'h00_0000, s_reg.cfi_subchannel_select_reg};
            end else if (ADR_I == OFS_STAT) begin
                s_next.dat = {16'h0000, 8'(s_reg.slot), 7'h00, s_reg.pend};
            end
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            s_reg <= '0;
            s_reg.cfi_tx <= IDLE_BYTE;
            s_reg.mem_access_data_reg <= RST_BYTE;
            s_reg.cfi_subchannel_select_reg <= RST_BYTE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign DAT_O = s_reg.dat;
    assign ACK_O = s_reg.ack;
    assign PCM_TX_DATA = s_reg.pcm_tx;
    assign PCM_TX_OE = s_reg.pcm_oe;
    assign CFI_TX_DATA = s_reg.cfi_tx;
    assign TX_SLOT = s_reg.tx_slot;
endmodule

// [sim/pcm_cfi_lines.sv]
// Far-side model: PCM highway with pull-up and interface receive lines
`timescale 1ns/1ps
module pcm_cfi_lines (
    input wire logic clk,
    input wire logic [7:0] pcm_val,
    input wire logic [7:0] cfi_val,
    input wire logic [7:0] tx_data,
    input wire logic [7:0] tx_oe,
    output logic [7:0] pcm_rx,
    output logic [7:0] cfi_rx,
    output logic [7:0] line
);
    initial begin
        pcm_rx = 8'h00;
        cfi_rx = 8'h00;
    end
    always @(posedge clk) begin
        pcm_rx <= pcm_val;
        cfi_rx <= cfi_val;
    end
    // Released bits float to the pull-up, so a withheld slot reads all ones
    assign line = (tx_data & tx_oe) | ~tx_oe;
endmodule

// [sim/subch_sva.sv]
// Port-level checker for the subchannel switch
`timescale 1ns/1ps
module subch_sva
    import subch_pkg::*;
#(
    parameter int NSLOT = 32,
    parameter int SW = 5
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [4:0] ADR_I,
    input wire logic [31:0] DAT_O,
    input wire logic ACK_O,
    input wire logic [7:0] PCM_TX_OE,
    input wire logic [SW-1:0] TX_SLOT
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RSTN);
    ack_timing_a: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
        else $error("no ack one cycle after request");
    ack_pulse_a: assert property (ACK_O |=> !ACK_O)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (ACK_O |-> $past(CYC_I && STB_I))
        else $error("ack without request");
    dat_idle_a: assert property (!ACK_O |-> DAT_O == 32'h0)
        else $error("read data outside ack");
    dat_upper_a: assert property (DAT_O[31:8] == 24'h0)
        else $error("upper read bits not zero");
    unmapped_read_a: assert property (CYC_I && STB_I && !WE_I && !ACK_O && ADR_I > OFS_STAT
        |=> DAT_O == 32'h0) else $error("unmapped read not zero");
    slot_step_a: assert property ($past(RSTN, 2) |-> TX_SLOT ==
        (($past(TX_SLOT) == SW'(NSLOT - 1)) ? '0 : $past(TX_SLOT) + 1'b1))
        else $error("slot index did not step");
    oe_pairs_a: assert property (PCM_TX_OE[7] == PCM_TX_OE[6] && PCM_TX_OE[5] == PCM_TX_OE[4]
        && PCM_TX_OE[3] == PCM_TX_OE[2] && PCM_TX_OE[1] == PCM_TX_OE[0])
        else $error("drive enables not paired");
endmodule
bind subchannel_loop_switch_control subch_sva #(.NSLOT(NSLOT), .SW(SW)) u_subch_sva (
    .CLK(CLK), .RSTN(RSTN), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I),
    .DAT_O(DAT_O), .ACK_O(ACK_O), .PCM_TX_OE(PCM_TX_OE), .TX_SLOT(TX_SLOT));

// [sim/subchannel_loop_switch_control_tb.sv]
// Self-checking bench for the subchannel switch
`timescale 1ns/1ps
module subchannel_loop_switch_control_tb
    import subch_pkg::*;
;
    logic CLK, RSTN, cyc, stb, we, ACK_O;
    logic [4:0] adr, TX_SLOT;
    logic [31:0] dat_w, DAT_O, q;
    logic [7:0] pcm_val, cfi_val, pcm_rx, cfi_rx, PCM_TX_DATA, PCM_TX_OE, CFI_TX_DATA, pcm_line;
    logic [3:0] t;
    int fails, checks;
    logic [3:0] codes [7] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8};
    logic [1:0] sels [4] = '{2'h3, 2'h1, 2'h2, 2'h0};
    subchannel_loop_switch_control #(.NSLOT(32), .SW(5)) u_subchannel_loop_switch_control (
        .CLK(CLK), .RSTN(RSTN), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
        .DAT_I(dat_w), .SEL_I(4'hF), .DAT_O(DAT_O), .ACK_O(ACK_O), .PCM_RX_DATA(pcm_rx),
        .CFI_RX_DATA(cfi_rx), .PCM_TX_DATA(PCM_TX_DATA), .PCM_TX_OE(PCM_TX_OE),
        .CFI_TX_DATA(CFI_TX_DATA), .TX_SLOT(TX_SLOT));
    pcm_cfi_lines u_pcm_cfi_lines (.clk(CLK), .pcm_val(pcm_val), .cfi_val(cfi_val),
        .tx_data(PCM_TX_DATA), .tx_oe(PCM_TX_OE), .pcm_rx(pcm_rx), .cfi_rx(cfi_rx),
        .line(pcm_line));
    // Placement model: subchannel bits copied, all other interface bits idle high
    function automatic logic [7:0] exp_cfi(logic [3:0] c, logic [1:0] s, logic [7:0] v);
        int pl, w, cl;
        logic [7:0] r;
        r = 8'hFF;
        pl = (c == 4'h3 || c == 4'h7) ? ((c == 4'h3) ? 4 : 6) : ((c == 4'h6) ? 2 : 0);
        w = (c == 4'h1) ? 8 : (c == 4'h3) ? 4 : (c == 4'h4 || c == 4'h6 || c == 4'h7) ? 2 : 0;
        case (s)
            2'h3: cl = 0;
            2'h1: cl = (w == 2) ? 4 : 0;
            2'h2: cl = (w == 2) ? 2 : 4;
            default: cl = (w == 2) ? 6 : 4;
        endcase
        if (w == 8) cl = 0;
        for (int i = 0; i < w; i++) r[cl + i] = v[pl + i];
        return r;
    endfunction
    function automatic logic [7:0] exp_oe(logic [3:0] f);
        logic [7:0] r;
        for (int k = 0; k < 8; k++) r[k] = f[k / 2];
        return r;
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge CLK);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= {24'h0, d};
        do begin
            @(posedge CLK);
            n++;
        end while (ACK_O !== 1'b1 && n < 50);
        if (n >= 50) fails++;
        q = DAT_O;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge CLK);
    endtask
    task automatic mem_op(input logic [7:0] a, input logic [7:0] d, input logic [7:0] op);
        bus(1'b1, OFS_DATA, d);
        bus(1'b1, OFS_ADDR, a);
        bus(1'b1, OFS_CTRL, op);
        repeat (2) @(posedge CLK);
    endtask
    task automatic at_slot(input logic [4:0] s);
        int n;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (TX_SLOT !== s && n < 40);
        // A slot that never comes round means the frame counter has stalled
        if (n >= 40) fails++;
    endtask
    task automatic tally_and_finish();
        if (fails == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end
    initial begin
        repeat (20000) @(posedge CLK);
        fails++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(16));
        {RSTN, cyc, stb, we, adr, dat_w, cfi_val} = '0;
        pcm_val = 8'($urandom);
        repeat (4) @(posedge CLK);
        RSTN <= 1'b1;
        bus(1'b1, OFS_DATA, 8'hA5);
        bus(1'b0, OFS_DATA, 8'h00);
        chk("data reg", 32'hA5, q);
        bus(1'b0, 5'h14, 8'h00);
        chk("unmapped", 32'h0, q);
        foreach (sels[j]) begin
            bus(1'b1, OFS_CSEL, {4'h0, sels[j], 2'h0});
            foreach (codes[i]) begin
                pcm_val <= 8'($urandom);
                mem_op(8'h05, 8'h09, {OP_CM_WRITE, codes[i]});
                bus(1'b1, OFS_CTRL, OP_CODE_READ);
                bus(1'b0, OFS_DATA, 8'h00);
                chk("code", {28'h0, codes[i]}, q);
                bus(1'b1, OFS_CTRL, OP_PTR_READ);
                bus(1'b0, OFS_DATA, 8'h00);
                chk("pointer", 32'h09, q);
                repeat (40) @(posedge CLK);
                at_slot(5'd5);
                chk("cfi out", {24'h0, exp_cfi(codes[i], sels[j], pcm_val)}, {24'h0, CFI_TX_DATA});
            end
        end
        mem_op(8'h05, 8'h0A, OP_PTR_WRITE);
        bus(1'b1, OFS_CTRL, OP_PTR_READ);
        bus(1'b0, OFS_DATA, 8'h00);
        chk("pointer only", 32'h0A, q);
        bus(1'b1, OFS_CTRL, OP_CODE_READ);
        bus(1'b0, OFS_DATA, 8'h00);
        chk("code kept", {28'h0, codes[6]}, q);
        for (int i = 0; i < 3; i++) begin
            t = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'($urandom);
            mem_op(8'h0C, {4'h0, t}, OP_TS_WRITE);
            at_slot(5'd12);
            chk("drive enable", {24'h0, exp_oe(t)}, {24'h0, PCM_TX_OE});
        end
        cfi_val <= 8'($urandom);
        mem_op(8'h83, 8'h8C, {OP_CM_WRITE, CODE_64K});
        mem_op(8'h07, 8'h8C, {OP_CM_WRITE, CODE_64K});
        mem_op(8'h0C, 8'h0F, OP_TS_WRITE);
        repeat (40) @(posedge CLK);
        at_slot(5'd12);
        chk("pcm line", {24'h0, cfi_val}, {24'h0, pcm_line});
        at_slot(5'd7);
        chk("cfi loop", {24'h0, cfi_val}, {24'h0, CFI_TX_DATA});
        mem_op(8'h0C, 8'h00, OP_TS_WRITE);
        at_slot(5'd12);
        chk("released line", 32'hFF, {24'h0, pcm_line});
        mem_op(8'h14, 8'h0D, {OP_CM_WRITE, CODE_64K});
        mem_op(8'h94, 8'h05, {OP_CM_WRITE, CODE_64K});
        mem_op(8'h05, 8'h0F, OP_TS_WRITE);
        repeat (70) @(posedge CLK);
        at_slot(5'd5);
        chk("pcm loop", {24'h0, pcm_val}, {24'h0, pcm_line});
        tally_and_finish();
    end
endmodule
